/* File: design/fid_pkg.sv */
// Shared constants, operation codes and state carrier of the instruction decoder
`default_nettype none
package fid_pkg;
  // Bus geometry and answers
  localparam int AXI_AW = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register byte addresses
  localparam logic [7:0] OFF_INSN = 8'h00;
  localparam logic [7:0] OFF_WORK = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PCHI = 8'h0c;
  localparam logic [7:0] OFF_PTR0 = 8'h10;
  localparam logic [7:0] OFF_PTR1 = 8'h14;
  localparam logic [7:0] OFF_FADDR = 8'h18;
  localparam logic [7:0] OFF_FDATA = 8'h1c;
  localparam logic [7:0] OFF_CYCLES = 8'h20;
  // Status register fields
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_BUSY = 8;
  localparam int ST_SKIP = 9;
  localparam int ST_READ = 10;
  localparam int ST_UNSUP = 11;
  // Instruction word fields
  localparam int INSN_W = 14;
  localparam int DBIT = 7;
  localparam int BIT_LO = 7;
  localparam int FILE_AW = 7;
  localparam int FILE_N = 128;
  // Timing: one instruction cycle is four clock phases
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PER_ICYC = 4;
  localparam logic [1:0] LAST_PHASE = 2'(OSC_PER_ICYC - 1);
  // Reset values
  localparam logic [7:0] RST_WORK = 8'h00;
  localparam logic [15:0] RST_PTR = 16'h0000;

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_NOP} fid_state_e;

  typedef enum logic [4:0] {
    OP_NONE, OP_ADD_FILE, OP_ADD_FILE_CARRY, OP_AND_FILE, OP_CLEAR_FILE, OP_COMP_FILE,
    OP_DEC_FILE, OP_INC_FILE, OP_OR_FILE, OP_MOVE_FILE, OP_STORE_WORK, OP_ROT_LEFT,
    OP_ROT_RIGHT, OP_SUB_FILE, OP_SUB_FILE_BORROW, OP_SWAP_FILE, OP_XOR_FILE,
    OP_DEC_SKIP, OP_INC_SKIP, OP_BIT_CLEAR, OP_BIT_SET, OP_TEST_CLEAR, OP_TEST_SET,
    OP_ADD_LIT, OP_AND_LIT, OP_OR_LIT, OP_LOAD_HIGH, OP_MOVE_LIT, OP_LIT_SUB, OP_XOR_LIT
  } fid_op_e;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_full;
    logic w_full;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fid_axi_s;

  typedef struct packed {
    fid_state_e st;
    logic [1:0] phase;
    logic [1:0] extra;
    logic [1:0] cycles;
    logic [INSN_W-1:0] insn;
    logic [7:0] opnd;
    logic [7:0] work;
    logic c;
    logic dc;
    logic z;
    logic skip;
    logic rd_seen;
    logic unsup;
    logic [6:0] pchi;
    logic [1:0][15:0] ptr;
    logic [FILE_AW-1:0] faddr;
    logic [FILE_N-1:0][7:0] file;
    fid_axi_s axi;
  } fid_core_s;
endpackage
`default_nettype wire

/* File: design/fid_decoder.sv */
// Fourteen-bit instruction decoder and executor with an AXI4-Lite register port
`timescale 1ns/1ps
`default_nettype none
module fid_decoder
  import fid_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // Opcode match; operand bits are wildcards so don't-care positions cannot steer it
  function automatic fid_op_e decode_op(input logic [INSN_W-1:0] iw);
    fid_op_e op;
    op = OP_NONE;
    casez (iw)
      14'b00_0111_????_????: op = OP_ADD_FILE;
      14'b11_1101_????_????: op = OP_ADD_FILE_CARRY;
      14'b00_0101_????_????: op = OP_AND_FILE;
      14'b00_0001_1???_????: op = OP_CLEAR_FILE;
      14'b00_1001_????_????: op = OP_COMP_FILE;
      14'b00_0011_????_????: op = OP_DEC_FILE;
      14'b00_1010_????_????: op = OP_INC_FILE;
      14'b00_0100_????_????: op = OP_OR_FILE;
      14'b00_1000_????_????: op = OP_MOVE_FILE;
      14'b00_0000_1???_????: op = OP_STORE_WORK;
      14'b00_1101_????_????: op = OP_ROT_LEFT;
      14'b00_1100_????_????: op = OP_ROT_RIGHT;
      14'b00_0010_????_????: op = OP_SUB_FILE;
      14'b11_1011_????_????: op = OP_SUB_FILE_BORROW;
      14'b00_1110_????_????: op = OP_SWAP_FILE;
      14'b00_0110_????_????: op = OP_XOR_FILE;
      14'b00_1011_????_????: op = OP_DEC_SKIP;
      14'b00_1111_????_????: op = OP_INC_SKIP;
      14'b01_00??_????_????: op = OP_BIT_CLEAR;
      14'b01_01??_????_????: op = OP_BIT_SET;
      14'b01_10??_????_????: op = OP_TEST_CLEAR;
      14'b01_11??_????_????: op = OP_TEST_SET;
      14'b11_1110_????_????: op = OP_ADD_LIT;
      14'b11_1001_????_????: op = OP_AND_LIT;
      14'b11_1000_????_????: op = OP_OR_LIT;
      14'b11_0001_1???_????: op = OP_LOAD_HIGH;
      14'b11_0000_????_????: op = OP_MOVE_LIT;
      14'b11_1100_????_????: op = OP_LIT_SUB;
      14'b11_1010_????_????: op = OP_XOR_LIT;
      default: op = OP_NONE;
    endcase
    return op;
  endfunction

  // Byte add returning {carry, digit carry, sum}; subtraction feeds the inverted working register
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    return {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  // Byte-lane merge of a bus write into an old register value
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  fid_core_s s_reg;
  fid_core_s s_next;
  fid_op_e op;
  logic is_file;
  logic dgrp;
  logic ind;
  logic ind_ext;
  logic [FILE_AW-1:0] eff;
  logic [2:0] bpos;
  logic [7:0] lit;
  logic [7:0] alu_res;
  logic fl_c;
  logic fl_dc;
  logic fl_z;
  logic upd_z;
  logic to_file;
  logic to_work;
  logic skip_now;
  logic exec_wr;
  logic [9:0] sum;
  logic [31:0] stat_word;

  // Operand fields and indirect target resolution
  always_comb begin
    op = decode_op(s_reg.insn);
    is_file = (op inside {[OP_ADD_FILE:OP_TEST_SET]});
    bpos = s_reg.insn[BIT_LO +: 3];
    lit = s_reg.insn[7:0];
    ind = (s_reg.insn[FILE_AW-1:1] == 6'h00);
    // Low address bit numbers the pointer pair behind the indirect register
    eff = ind ? s_reg.ptr[s_reg.insn[0]][FILE_AW-1:0] : s_reg.insn[FILE_AW-1:0];
    ind_ext = is_file && ind && s_reg.ptr[s_reg.insn[0]][15];
    exec_wr = (s_reg.st == S_EXEC) && (s_reg.phase == LAST_PHASE);
  end

  // Arithmetic unit, fed by the operand captured in the first phase
  always_comb begin
    alu_res = s_reg.opnd;
    fl_c = s_reg.c;
    fl_dc = s_reg.dc;
    fl_z = s_reg.z;
    upd_z = 1'b0;
    dgrp = 1'b1;
    to_file = 1'b0;
    to_work = 1'b0;
    skip_now = 1'b0;
    sum = 10'h000;
    unique case (op)
      OP_ADD_FILE: begin
        sum = add8(s_reg.opnd, s_reg.work, 1'b0);
        {fl_c, fl_dc, alu_res} = sum;
        upd_z = 1'b1;
      end
      OP_ADD_FILE_CARRY: begin
        sum = add8(s_reg.opnd, s_reg.work, s_reg.c);
        {fl_c, fl_dc, alu_res} = sum;
        upd_z = 1'b1;
      end
      OP_SUB_FILE: begin
        sum = add8(s_reg.opnd, ~s_reg.work, 1'b1);
        {fl_c, fl_dc, alu_res} = sum;
        upd_z = 1'b1;
      end
      OP_SUB_FILE_BORROW: begin
        // Carry set means no borrow pending, so it feeds the carry-in directly
        sum = add8(s_reg.opnd, ~s_reg.work, s_reg.c);
        {fl_c, fl_dc, alu_res} = sum;
        upd_z = 1'b1;
      end
      OP_AND_FILE: begin
        alu_res = s_reg.opnd & s_reg.work;
        upd_z = 1'b1;
      end
      OP_OR_FILE: begin
        alu_res = s_reg.opnd | s_reg.work;
        upd_z = 1'b1;
      end
      OP_XOR_FILE: begin
        alu_res = s_reg.opnd ^ s_reg.work;
        upd_z = 1'b1;
      end
      OP_CLEAR_FILE: begin
        alu_res = 8'h00;
        upd_z = 1'b1;
        dgrp = 1'b0;
        to_file = 1'b1;
      end
      OP_STORE_WORK: begin
        alu_res = s_reg.work;
        dgrp = 1'b0;
        to_file = 1'b1;
      end
      OP_COMP_FILE: begin
        alu_res = ~s_reg.opnd;
        upd_z = 1'b1;
      end
      OP_DEC_FILE: begin
        alu_res = s_reg.opnd - 8'h01;
        upd_z = 1'b1;
      end
      OP_INC_FILE: begin
        alu_res = s_reg.opnd + 8'h01;
        upd_z = 1'b1;
      end
      OP_MOVE_FILE: begin
        upd_z = 1'b1;
      end
      OP_ROT_LEFT: begin
        {fl_c, alu_res} = {s_reg.opnd, s_reg.c};
      end
      OP_ROT_RIGHT: begin
        {alu_res, fl_c} = {s_reg.c, s_reg.opnd};
      end
      OP_SWAP_FILE: begin
        alu_res = {s_reg.opnd[3:0], s_reg.opnd[7:4]};
      end
      OP_DEC_SKIP: begin
        alu_res = s_reg.opnd - 8'h01;
        skip_now = (alu_res == 8'h00);
      end
      OP_INC_SKIP: begin
        alu_res = s_reg.opnd + 8'h01;
        skip_now = (alu_res == 8'h00);
      end
      OP_BIT_CLEAR: begin
        alu_res[bpos] = 1'b0;
        dgrp = 1'b0;
        to_file = 1'b1;
      end
      OP_BIT_SET: begin
        alu_res[bpos] = 1'b1;
        dgrp = 1'b0;
        to_file = 1'b1;
      end
      OP_TEST_CLEAR: begin
        skip_now = ~s_reg.opnd[bpos];
        dgrp = 1'b0;
      end
      OP_TEST_SET: begin
        skip_now = s_reg.opnd[bpos];
        dgrp = 1'b0;
      end
      OP_ADD_LIT: begin
        sum = add8(lit, s_reg.work, 1'b0);
        {fl_c, fl_dc, alu_res} = sum;
        upd_z = 1'b1;
      end
      OP_LIT_SUB: begin
        sum = add8(lit, ~s_reg.work, 1'b1);
        {fl_c, fl_dc, alu_res} = sum;
        upd_z = 1'b1;
      end
      OP_AND_LIT: begin
        alu_res = lit & s_reg.work;
        upd_z = 1'b1;
      end
      OP_OR_LIT: begin
        alu_res = lit | s_reg.work;
        upd_z = 1'b1;
      end
      OP_XOR_LIT: begin
        alu_res = lit ^ s_reg.work;
        upd_z = 1'b1;
      end
      OP_MOVE_LIT: begin
        alu_res = lit;
      end
      OP_LOAD_HIGH: begin
        dgrp = 1'b0;
      end
      OP_NONE: begin
        dgrp = 1'b0;
      end
    endcase
    if (upd_z) begin
      fl_z = (alu_res == 8'h00);
    end
    if (is_file && dgrp) begin
      to_file = s_reg.insn[DBIT];
      to_work = ~s_reg.insn[DBIT];
    end
    if (op inside {[OP_ADD_LIT:OP_XOR_LIT]} && op != OP_LOAD_HIGH) begin
      to_work = 1'b1;
    end
  end

  // Status word as software sees it
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[ST_C] = s_reg.c;
    stat_word[ST_DC] = s_reg.dc;
    stat_word[ST_Z] = s_reg.z;
    stat_word[ST_BUSY] = (s_reg.st != S_IDLE);
    stat_word[ST_SKIP] = s_reg.skip;
    stat_word[ST_READ] = s_reg.rd_seen;
    stat_word[ST_UNSUP] = s_reg.unsup;
  end

  // Next state: sequencer, execution and bus slave in one pass
  always_comb begin
    logic [31:0] mw;
    logic [31:0] rd;
    logic idle;
    s_next = s_reg;
    mw = 32'h0000_0000;
    rd = 32'h0000_0000;
    idle = (s_reg.st == S_IDLE);
    // Four-phase instruction cycle; phase free-runs only while busy
    if (!idle) begin
      s_next.phase = s_reg.phase + 2'h1;
    end
    unique case (s_reg.st)
      S_IDLE: begin
        s_next.phase = 2'h0;
      end
      S_EXEC: begin
        if (s_reg.phase == 2'h0) begin
          // Every file instruction reads first, even a pure store
          s_next.opnd = is_file ? s_reg.file[eff] : 8'h00;
          s_next.rd_seen = is_file;
        end
        if (exec_wr) begin
          if (to_work) begin
            s_next.work = alu_res;
          end
          if (to_file) begin
            s_next.file[eff] = alu_res;
          end
          if (op == OP_LOAD_HIGH) begin
            s_next.pchi = s_reg.insn[6:0];
          end
          s_next.c = fl_c;
          s_next.dc = fl_dc;
          s_next.z = fl_z;
          s_next.skip = skip_now;
          s_next.unsup = (op == OP_NONE);
          // Taken skip and program-memory indirect each add one no-op cycle
          s_next.extra = {1'b0, skip_now} + {1'b0, ind_ext};
          s_next.cycles = 2'h1 + {1'b0, skip_now} + {1'b0, ind_ext};
          s_next.st = (skip_now || ind_ext) ? S_NOP : S_IDLE;
        end
      end
      S_NOP: begin
        // Filler cycle touches no state besides its own count
        if (s_reg.phase == LAST_PHASE) begin
          s_next.extra = s_reg.extra - 2'h1;
          if (s_reg.extra == 2'h1) begin
            s_next.st = S_IDLE;
          end
        end
      end
      default: begin
        s_next.st = S_IDLE;
      end
    endcase

    // Write channels are captured independently, in either order
    if (awvalid && s_reg.axi.awready) begin
      s_next.axi.aw_full = 1'b1;
      s_next.axi.awaddr = awaddr;
    end
    if (wvalid && s_reg.axi.wready) begin
      s_next.axi.w_full = 1'b1;
      s_next.axi.wdata = wdata;
      s_next.axi.wstrb = wstrb;
    end
    if (bready && s_reg.axi.bvalid) begin
      s_next.axi.bvalid = 1'b0;
    end
    // Writes are ignored while an instruction runs so execution owns the state
    if (s_reg.axi.aw_full && s_reg.axi.w_full && !s_reg.axi.bvalid) begin
      s_next.axi.aw_full = 1'b0;
      s_next.axi.w_full = 1'b0;
      s_next.axi.bvalid = 1'b1;
      s_next.axi.bresp = RESP_OKAY;
      unique case ({s_reg.axi.awaddr[7:2], 2'b00})
        OFF_INSN: begin
          mw = lanes({18'h0, s_reg.insn}, s_reg.axi.wdata, s_reg.axi.wstrb);
          if (idle) begin
            s_next.insn = mw[INSN_W-1:0];
            s_next.st = S_EXEC;
            s_next.phase = 2'h0;
          end
        end
        OFF_WORK: begin
          mw = lanes({24'h0, s_reg.work}, s_reg.axi.wdata, s_reg.axi.wstrb);
          if (idle) begin
            s_next.work = mw[7:0];
          end
        end
        OFF_STATUS: begin
          mw = lanes(stat_word, s_reg.axi.wdata, s_reg.axi.wstrb);
          if (idle) begin
            s_next.c = mw[ST_C];
            s_next.dc = mw[ST_DC];
            s_next.z = mw[ST_Z];
          end
        end
        OFF_PCHI: begin
          mw = lanes({25'h0, s_reg.pchi}, s_reg.axi.wdata, s_reg.axi.wstrb);
          if (idle) begin
            s_next.pchi = mw[6:0];
          end
        end
        OFF_PTR0, OFF_PTR1: begin
          mw = lanes({16'h0, s_reg.ptr[s_reg.axi.awaddr[2]]}, s_reg.axi.wdata, s_reg.axi.wstrb);
          if (idle) begin
            s_next.ptr[s_reg.axi.awaddr[2]] = mw[15:0];
          end
        end
        OFF_FADDR: begin
          mw = lanes({25'h0, s_reg.faddr}, s_reg.axi.wdata, s_reg.axi.wstrb);
          if (idle) begin
            s_next.faddr = mw[FILE_AW-1:0];
          end
        end
        OFF_FDATA: begin
          mw = lanes({24'h0, s_reg.file[s_reg.faddr]}, s_reg.axi.wdata, s_reg.axi.wstrb);
          if (idle) begin
            s_next.file[s_reg.faddr] = mw[7:0];
          end
        end
        OFF_CYCLES: begin
          s_next.axi.bresp = RESP_OKAY;
        end
        default: begin
          s_next.axi.bresp = RESP_SLVERR;
        end
      endcase
    end

    // Read channel: one beat answered the cycle after the address is taken
    if (rready && s_reg.axi.rvalid) begin
      s_next.axi.rvalid = 1'b0;
    end
    if (arvalid && s_reg.axi.arready) begin
      s_next.axi.rvalid = 1'b1;
      s_next.axi.rresp = RESP_OKAY;
      unique case ({araddr[7:2], 2'b00})
        OFF_INSN: rd = {18'h0, s_reg.insn};
        OFF_WORK: rd = {24'h0, s_reg.work};
        OFF_STATUS: rd = stat_word;
        OFF_PCHI: rd = {25'h0, s_reg.pchi};
        OFF_PTR0: rd = {16'h0, s_reg.ptr[0]};
        OFF_PTR1: rd = {16'h0, s_reg.ptr[1]};
        OFF_FADDR: rd = {25'h0, s_reg.faddr};
        OFF_FDATA: rd = {24'h0, s_reg.file[s_reg.faddr]};
        OFF_CYCLES: rd = {30'h0, s_reg.cycles};
        default: s_next.axi.rresp = RESP_SLVERR;
      endcase
      s_next.axi.rdata = rd;
    end
    s_next.axi.awready = !s_next.axi.aw_full;
    s_next.axi.wready = !s_next.axi.w_full;
    s_next.axi.arready = !s_next.axi.rvalid;
  end

  // State register; all-zero reset leaves every handshake output low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.work <= RST_WORK;
      s_reg.ptr <= {RST_PTR, RST_PTR};
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready = s_reg.axi.awready;
  assign wready = s_reg.axi.wready;
  assign bvalid = s_reg.axi.bvalid;
  assign bresp = s_reg.axi.bresp;
  assign arready = s_reg.axi.arready;
  assign rvalid = s_reg.axi.rvalid;
  assign rdata = s_reg.axi.rdata;
  assign rresp = s_reg.axi.rresp;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence seq_nop_cycle;
    (s_reg.st == S_NOP) [*4];
  endsequence

  sequence seq_exec_cycle;
    (s_reg.st == S_EXEC && s_reg.phase == 2'h0) ##3 exec_wr;
  endsequence

  a_phase_count: assert property ($rose(s_reg.st == S_EXEC) |-> seq_exec_cycle)
    else $error("instruction cycle is not four clocks");
  a_read_first: assert property (exec_wr && is_file |-> s_reg.rd_seen && s_reg.opnd == $past(s_reg.file[eff], 3))
    else $error("file operand not read before write");
  a_dest_work: assert property (exec_wr && is_file && dgrp && !s_reg.insn[DBIT] |=> s_reg.work == $past(alu_res))
    else $error("result did not reach working register");
  a_dest_file: assert property (exec_wr && to_file |=> s_reg.file[$past(eff)] == $past(alu_res))
    else $error("result did not reach file register");
  a_one_bit_change: assert property (exec_wr && op inside {OP_BIT_CLEAR, OP_BIT_SET} |->
      ((alu_res ^ s_reg.opnd) & ~(8'h01 << bpos)) == 8'h00)
    else $error("bit operation disturbed other bits");
  a_skip_extends: assert property (exec_wr && skip_now && !ind_ext |=> seq_nop_cycle ##1 s_reg.st == S_IDLE)
    else $error("skip did not add one no-op cycle");
  a_ind_extends: assert property (exec_wr && ind_ext && !skip_now |=> seq_nop_cycle ##1 s_reg.st == S_IDLE)
    else $error("indirect access did not add one cycle");
  a_rotate_flags: assert property (exec_wr && op inside {OP_ROT_LEFT, OP_ROT_RIGHT} |=>
      $stable(s_reg.dc) && $stable(s_reg.z))
    else $error("rotate changed digit carry or zero");
  a_high_latch: assert property (exec_wr && op == OP_LOAD_HIGH |=>
      s_reg.pchi == $past(s_reg.insn[6:0]) && $stable({s_reg.c, s_reg.dc, s_reg.z}))
    else $error("high latch load wrong or flags touched");
  a_logic_carry: assert property (exec_wr && op inside {OP_OR_FILE, OP_XOR_FILE, OP_OR_LIT, OP_XOR_LIT} |=>
      $stable(s_reg.c) && $stable(s_reg.dc))
    else $error("logic operation changed carry flags");
  // Judged against the stored byte itself, so a broken operand path cannot hide a wrong skip
  a_test_skip: assert property (exec_wr && op inside {OP_TEST_CLEAR, OP_TEST_SET} |=>
      s_reg.skip == ($past(s_reg.file[eff][bpos]) == $past(op == OP_TEST_SET)))
    else $error("bit test skip decision wrong");
endmodule
`default_nettype wire

/* File: bench/fid_prog_mem.sv */
// Program memory model feeding instruction words to the bench
`timescale 1ns/1ps
`default_nettype none
module fid_prog_mem
  import fid_pkg::*;
(
  input wire logic [3:0] idx,
  output logic [INSN_W-1:0] word
);
  // Fixed program, each word one whole opcode with its operands
  always_comb begin
    case (idx)
      4'h0: word = 14'h3d85;
      4'h1: word = 14'h0b86;
      4'h2: word = 14'h1e05;
      4'h3: word = 14'h3c03;
      4'h4: word = 14'h31d5;
      4'h5: word = 14'h0f80;
      4'h6: word = 14'h1007;
      4'h7: word = 14'h0d07;
      // Borrow subtract, skip-if-clear through pointer one, then the OR and XOR forms
      4'h8: word = 14'h3b85;
      4'h9: word = 14'h1801;
      4'ha: word = 14'h0407;
      4'hb: word = 14'h3a31;
      4'hc: word = 14'h3880;
      default: word = 14'h0685;
    endcase
  end
endmodule
`default_nettype wire

/* File: bench/tb_fid_decoder.sv */
// Bus-level testbench of the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb_fid_decoder
  import fid_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [3:0] pc;
  logic [INSN_W-1:0] word;
  int n_fail = 0;
  int total_checks = 0;
  int n;
  // Setup writes, then per step: result register, file index, value, cycles
  logic [7:0] sa [10] = '{OFF_FADDR, OFF_FDATA, OFF_FADDR, OFF_FDATA, OFF_FADDR, OFF_FDATA, OFF_WORK,
    OFF_STATUS, OFF_PTR0, OFF_PTR1};
  logic [31:0] sd [10] = '{32'h05, 32'h0f, 32'h06, 32'h01, 32'h07, 32'h10, 32'h01, 32'h01, 32'h8007,
    32'h06};
  logic [7:0] ca [14] = '{OFF_FDATA, OFF_STATUS, OFF_STATUS, OFF_WORK, OFF_PCHI, OFF_FDATA, OFF_FDATA,
    OFF_WORK, OFF_FDATA, OFF_STATUS, OFF_WORK, OFF_STATUS, OFF_WORK, OFF_FDATA};
  logic [7:0] fa [14] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'h05, 8'h07, 8'h07, 8'h07, 8'h05, 8'h05, 8'h05,
    8'h05, 8'h05, 8'h05};
  logic [31:0] ev [14] = '{32'h11, 32'h202, 32'h202, 32'h02, 32'h55, 32'h11, 32'h10, 32'h21, 32'hef,
    32'h200, 32'h31, 32'h04, 32'h80, 32'h6f};
  logic [1:0] cy [14] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1, 2'h1,
    2'h1};

  fid_decoder uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  fid_prog_mem prog (.idx(pc), .word(word));

  // Free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // Waits are bounded; a hang counts as a failure
  task automatic tmo(input int k);
    if (k >= 60) begin
      n_fail++;
      stop_test();
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 60);
    // Every address this bench writes is mapped, so the answer must be OKAY
    chk({30'h0, bresp}, {30'h0, RESP_OKAY});
    bready <= 1'b0;
    tmo(k);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 60);
    v = rdata;
    rr = rresp;
    rready <= 1'b0;
    tmo(k);
  endtask

  // Load operands, then run each program word and check its result and cost
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    pc = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h24, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 10; i++) wr(sa[i], sd[i]);
    for (int i = 0; i < 14; i++) begin
      pc <= 4'(i);
      @(posedge aclk);
      wr(OFF_INSN, {18'h0, word});
      n = 0;
      do begin
        rd(OFF_STATUS, d, r);
        n++;
      end while (d[ST_BUSY] !== 1'b0 && n < 60);
      tmo(n);
      rd(OFF_CYCLES, d, r);
      chk(d, {30'h0, cy[i]});
      wr(OFF_FADDR, {24'h0, fa[i]});
      rd(ca[i], d, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      chk(d & ((ca[i] == OFF_STATUS) ? 32'h207 : 32'hffffffff), ev[i]);
      chk(d & ((ca[i] == OFF_STATUS) ? 32'h207 : 32'hffffffff), ev[i]);
    end
    stop_test();
  end
endmodule
`default_nettype wire
